// ---- serial_link_test_and_framing_cfg.sv ----
/*
  ahb-lite register slave and two-link octet path: test pattern
  select, alignment device id and end-of-frame comma choice.
  assumes: single-slave ahb-lite, word transfers, one 40 mhz clock;
  lane octets go on to 8b/10b coders and serializers outside.
*/
// Implementation choice: register access over AHB-Lite.
// How it works
// - select zero sends normal link data
// - select one to nine picks test patterns
// - ten holds lanes low, eleven high
// - device id sent in second alignment multiframe
// - first link id as is, second plus one
// - id bit zero ignored, reads back zero
// - two-bit field picks opportunistic end-of-frame comma
// - codes zero, one, two map to commas
// - disabled link held in reset, powered down
`timescale 1ns/10ps
module serial_link_test_and_framing_cfg
  import link_cfg_pkg::*;
#(
  parameter int unsigned LINKS        = 2,
  parameter int unsigned FRAME_OCTETS = FRAME_OCTETS_DEF,
  parameter int unsigned MF_FRAMES    = MF_FRAMES_DEF
) (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output      logic                  hreadyout,
  output      logic [31:0]           hrdata,
  output      logic                  hresp,
  // sample octets from the transport layer, one per link
  input  wire logic [LINKS-1:0]      sample_valid,
  input  wire logic [LINKS-1:0][7:0] sample_data,
  output      logic [LINKS-1:0]      sample_ready,
  // octets toward the lane coders
  output      lane_sym_t [LINKS-1:0] lane_sym,
  output      logic [LINKS-1:0]      lane_valid,
  input  wire logic [LINKS-1:0]      lane_ready,
  // power and clock control of the serial side
  output      logic                  serializer_pd,
  output      logic                  link_clock_en
);
  // the device id increment is only defined for a pair of links
  initial begin
    if (LINKS != 2) $error("block serves exactly two links");
  end

  // register index match, shared by read and write decode
  function automatic logic hit(input logic [11:0] idx,
                               input logic [11:0] tgt);
    hit = (idx == tgt);
  endfunction

  // software-visible state
  logic                  link_enable_bit;          // link enable
  logic [TEST_SEL_W-1:0] link_test_pattern_select; // pattern code
  logic [DEV_ID_W-1:0]   ila_device_id;            // id, bit 0 zero
  logic [FRAME_END_CHAR_SELECT_W-1:0]    frame_end_char_select;    // comma code

  // bus data phase tracking
  logic        dp_active_reg;  // data phase open
  logic        dp_done_reg;    // wait state spent
  logic        dp_write_reg;   // phase is a write
  logic        dp_mapped_reg;  // address in our window
  logic [11:0] dp_idx_reg;     // word index
  logic [31:0] hrdata_reg;     // registered read data
  logic        addr_take;
  logic        wr_fire;
  logic [11:0] addr_idx;
  logic        addr_mapped;
  logic [31:0] rd_mux;

  // per-link wiring
  lane_sym_t [LINKS-1:0] gen_sym;
  logic [LINKS-1:0]      gen_valid;
  logic [LINKS-1:0]      gen_ready;
  logic [LINKS-1:0]      ila_done;
  logic [LINKS-1:0]      buf_valid;
  logic [7:0]            eof_code;
  logic [7:0]            id_even;
  logic                  run;

  // address phase is taken only with hready high
  assign addr_take   = hsel & htrans[1] & hready;
  assign addr_idx    = haddr[13:2];
  assign addr_mapped = (haddr[31:14] == 18'h0_0000) & (haddr[1:0] == 2'b00);
  // the first data-phase cycle does the work, the second answers
  assign wr_fire     = dp_active_reg & ~dp_done_reg & dp_write_reg &
                       dp_mapped_reg;
  assign hreadyout   = ~(dp_active_reg & ~dp_done_reg);
  assign hrdata      = hrdata_reg;
  assign hresp       = 1'b0;   // always okay

  // read selection; unmapped words and reserved bits read zero.
  // the mux feeds a register, so hrdata never sees a path from the
  // address; the price is one wait state on every transfer
  // status: bit 0 enable, bits 2:1 alignment done, bit 3 busy
  assign rd_mux =
    !dp_mapped_reg                     ? 32'h0000_0000 :
    hit(dp_idx_reg, IDX_LINK_CTRL)     ? {31'h0000_0000, link_enable_bit} :
    hit(dp_idx_reg, IDX_TEST_SEL)      ? {28'h000_0000,
                                          link_test_pattern_select} :
    hit(dp_idx_reg, IDX_DEV_ID)        ? {24'h00_0000, ila_device_id} :
    hit(dp_idx_reg, IDX_FRAME_END_CHAR_SELECT)         ? {30'h0000_0000,
                                          frame_end_char_select} :
    hit(dp_idx_reg, IDX_STATUS)        ? {28'h000_0000, |buf_valid,
                                          ila_done, run} :
                                         32'h0000_0000;

  // data phase sequencing; a new address phase waits for
  // hreadyout, so only one data phase is ever open
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dp_active_reg <= 1'b0;
      dp_done_reg   <= 1'b0;
      dp_write_reg  <= 1'b0;
      dp_mapped_reg <= 1'b0;
      dp_idx_reg    <= 12'h000;
    end else if (hreadyout) begin
      // a new address phase can only land when we are ready
      dp_active_reg <= addr_take;
      dp_done_reg   <= 1'b0;
      dp_write_reg  <= hwrite;
      dp_mapped_reg <= addr_mapped;
      dp_idx_reg    <= addr_idx;
    end else begin
      dp_done_reg   <= 1'b1;
    end
  end

  // read data captured during the wait cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) hrdata_reg <= 32'h0000_0000;
    else if (dp_active_reg && !dp_done_reg) hrdata_reg <= rd_mux;
  end

  // configuration registers; writes while enabled are taken as given,
  // software must stop the link first to get a clean restart
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      link_enable_bit          <= LINK_EN_RST;
      link_test_pattern_select <= TEST_SEL_RST;
      ila_device_id            <= DEV_ID_RST;
      frame_end_char_select    <= FRAME_END_CHAR_SELECT_RST;
    end else if (wr_fire) begin
      if (hit(dp_idx_reg, IDX_LINK_CTRL))
        link_enable_bit <= hwdata[LINK_EN_BIT];
      if (hit(dp_idx_reg, IDX_TEST_SEL))
        link_test_pattern_select <= hwdata[TEST_SEL_LSB +: TEST_SEL_W];
      if (hit(dp_idx_reg, IDX_DEV_ID))
        ila_device_id <= {hwdata[DEV_ID_LSB + 1 +: DEV_ID_W - 1], 1'b0};
      if (hit(dp_idx_reg, IDX_FRAME_END_CHAR_SELECT))
        frame_end_char_select <= hwdata[FRAME_END_CHAR_SELECT_LSB +: FRAME_END_CHAR_SELECT_W];
    end
  end

  // a cleared enable stops clocks, powers down and resets the path
  assign run           = link_enable_bit;
  assign serializer_pd = ~link_enable_bit;
  assign link_clock_en = link_enable_bit;
  assign eof_code      = eof_char(frame_end_char_select);
  assign id_even       = ila_device_id;

  // one generator and one buffer per link
  // links share settings and enable; only the id differs
  generate
    for (genvar i = 0; i < LINKS; i++) begin : g_link
      logic [7:0] lane_id;
      // second link adds one; bit 0 is zero so no carry out
      assign lane_id = id_even + 8'(i);

      link_pattern_gen #(
        .FRAME_OCTETS (FRAME_OCTETS),
        .MF_OCTETS    (MF_FRAMES * FRAME_OCTETS)
      ) u_gen (
        .clock        (clock),
        .sys_rst      (sys_rst),
        .run          (run),
        .mode         (test_mode_t'(link_test_pattern_select)),
        .eof_code     (eof_code),
        .lane_id      (lane_id),
        .sample_valid (sample_valid[i]),
        .sample_data  (sample_data[i]),
        .sample_ready (sample_ready[i]),
        .sym          (gen_sym[i]),
        .sym_valid    (gen_valid[i]),
        .sym_ready    (gen_ready[i]),
        .ila_done     (ila_done[i])
      );

      // a stalled lane coder holds two octets before back-pressure
      two_entry_buffer #(
        .WIDTH (11),
        .DEPTH (2)
      ) u_buf (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .flush     (~run),
        .in_valid  (gen_valid[i]),
        .in_data   (gen_sym[i]),
        .in_ready  (gen_ready[i]),
        .out_valid (buf_valid[i]),
        .out_data  (lane_sym[i]),
        .out_ready (lane_ready[i])
      );

      // nothing leaves a disabled link
      assign lane_valid[i] = buf_valid[i] & run;
    end
  endgenerate

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // register file: id handling and comma mapping
  id_even_a: assert property (
    wr_fire && hit(dp_idx_reg, IDX_DEV_ID)
    |=> ila_device_id == ($past(hwdata[7:0]) & 8'hFE))
    else $error("device id bit 0 not cleared");

  id_bit0_a: assert property (
    ila_device_id[0] == 1'b0)
    else $error("device id bit 0 set");

  id_step_a: assert property (
    g_link[1].lane_id == g_link[0].lane_id + 8'h01 &&
    g_link[0].lane_id == ila_device_id)
    else $error("link ids not id and id plus one");

  eof_map_a: assert property (
    frame_end_char_select == 2'b00 |-> eof_code == SYM_K28_7)
    else $error("comma code zero not mapped");

  comma_one_a: assert property (
    frame_end_char_select == 2'b01 |-> eof_code == SYM_K28_1)
    else $error("comma code one not mapped");

  eof_alt_a: assert property (
    frame_end_char_select == 2'b10 |-> eof_code == SYM_K28_5)
    else $error("comma code two not mapped");

  // reserved code must not leave the lanes without a comma
  comma_rsv_a: assert property (
    frame_end_char_select == 2'b11 |-> eof_code == SYM_K28_7)
    else $error("reserved comma code not on fallback");

  // lane path: pass-through, hold levels, disable
  normal_pass_a: assert property (
    run && link_test_pattern_select == 4'h0 && ila_done[0] &&
    gen_valid[0] && !gen_sym[0].k
    |-> gen_sym[0].data == sample_data[0] &&
        gen_sym[0].hold == HOLD_NONE)
    else $error("normal mode altered sample data");

  hold_lvl_a: assert property (
    run && link_test_pattern_select == 4'hA && gen_valid[1]
    |-> gen_sym[1].hold == HOLD_LOW)
    else $error("lanes not held low");

  hold_high_a: assert property (
    run && link_test_pattern_select == 4'hB && gen_valid[0]
    |-> gen_sym[0].hold == HOLD_HIGH)
    else $error("lanes not held high");

  // one edge later the flush must have emptied the buffers
  off_quiet_a: assert property (
    !link_enable_bit
    |-> lane_valid == '0 && serializer_pd && !link_clock_en &&
        sample_ready == '0 ##1 buf_valid == '0)
    else $error("disabled link still active");

  // bus timing: one wait state, then data with hready
  bus_wait_a: assert property (
    addr_take && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("data phase not two cycles");

  rd_data_a: assert property (
    dp_active_reg && !dp_done_reg
    |=> hreadyout && hrdata == $past(rd_mux))
    else $error("read data not shown with hready");

  // scenarios the bench should reach
  cov_prbs_c:  cover property (run && link_test_pattern_select == 4'h1
                               && lane_valid[0] && lane_ready[0]);
  cov_ila_c:   cover property (run && $rose(ila_done[1]));
  cov_stall_c: cover property (run && !gen_ready[0]);
  cov_eof_c:   cover property (lane_valid[0] && lane_sym[0].k &&
                               frame_end_char_select == 2'b01);
  cov_hold_c:  cover property (lane_valid[0] &&
                               lane_sym[0].hold == HOLD_HIGH);
endmodule

// ---- link_cfg_pkg.sv ----
/*
  shared constants, types and helpers for the lane test-pattern and
  framing configuration block.
  assumes: included before every module of the block.
*/
package link_cfg_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_LINK_CTRL = 12'h200;
  localparam logic [11:0] IDX_TEST_SEL  = 12'h205;
  localparam logic [11:0] IDX_DEV_ID    = 12'h206;
  localparam logic [11:0] IDX_FRAME_END_CHAR_SELECT     = 12'h207;
  localparam logic [11:0] IDX_STATUS    = 12'h20F;

  // field positions and widths
  localparam int unsigned LINK_EN_BIT  = 0;
  localparam int unsigned TEST_SEL_LSB = 0;
  localparam int unsigned TEST_SEL_W   = 4;
  localparam int unsigned DEV_ID_LSB   = 0;
  localparam int unsigned DEV_ID_W     = 8;
  localparam int unsigned FRAME_END_CHAR_SELECT_LSB    = 0;
  localparam int unsigned FRAME_END_CHAR_SELECT_W      = 2;

  // reset values
  localparam logic                  LINK_EN_RST  = 1'b1;
  localparam logic [TEST_SEL_W-1:0] TEST_SEL_RST = 4'h0;
  localparam logic [DEV_ID_W-1:0]   DEV_ID_RST   = 8'h00;
  localparam logic [FRAME_END_CHAR_SELECT_W-1:0]    FRAME_END_CHAR_SELECT_RST    = 2'h0;

  // framing: octets per frame, frames per multiframe, ila length
  localparam int unsigned FRAME_OCTETS_DEF = 1;
  localparam int unsigned MF_FRAMES_DEF    = 32;
  localparam int unsigned ILA_MFRAMES      = 4;

  // control and data characters before 8b/10b coding
  localparam logic [7:0] SYM_K28_0 = 8'h1C;
  localparam logic [7:0] SYM_K28_1 = 8'h3C;
  localparam logic [7:0] SYM_K28_3 = 8'h7C;
  localparam logic [7:0] SYM_K28_4 = 8'h9C;
  localparam logic [7:0] SYM_K28_5 = 8'hBC;
  localparam logic [7:0] SYM_K28_7 = 8'hFC;
  localparam logic [7:0] SYM_D21_5 = 8'hB5;

  // modified random pattern, sent first octet first
  localparam int unsigned RPAT_LEN = 12;
  localparam logic [95:0] RPAT_SEQ =
    96'h5935_FB5E_14B3_8F6B_4723_D7BE;

  typedef enum logic [3:0] {
    TP_NORMAL  = 4'b0000, TP_PRBS7   = 4'b0001, TP_PRBS15  = 4'b0010,
    TP_PRBS23  = 4'b0011, TP_RAMP    = 4'b0100, TP_TRANSP  = 4'b0101,
    TP_D21_5   = 4'b0110, TP_K28_5   = 4'b0111, TP_REP_ILA = 4'b1000,
    TP_RPAT    = 4'b1001, TP_LOW     = 4'b1010, TP_HIGH    = 4'b1011,
    TP_RSV12   = 4'b1100, TP_RSV13   = 4'b1101, TP_RSV14   = 4'b1110,
    TP_RSV15   = 4'b1111
  } test_mode_t;

  typedef enum logic [1:0] {
    HOLD_NONE = 2'b00, HOLD_LOW = 2'b01, HOLD_HIGH = 2'b10
  } hold_t;

  // one lane octet on its way to the serializer
  typedef struct packed {
    hold_t      hold;
    logic       k;
    logic [7:0] data;
  } lane_sym_t;

  // end-of-frame comma; reserved code falls back to the compliant one
  function automatic logic [7:0] eof_char(input logic [1:0] sel);
    case (sel)
      2'b01:   eof_char = SYM_K28_1;
      2'b10:   eof_char = SYM_K28_5;
      default: eof_char = SYM_K28_7;
    endcase
  endfunction

  // eight shifts of the selected prbs polynomial
  function automatic logic [22:0] prbs_step8(input logic [22:0] s,
                                             input test_mode_t m);
    logic [22:0] v;
    logic        fb;
    v = s;
    for (int i = 0; i < 8; i++) begin
      case (m)
        TP_PRBS7:  fb = v[6] ^ v[5];
        TP_PRBS15: fb = v[14] ^ v[13];
        default:   fb = v[22] ^ v[17];
      endcase
      v = {v[21:0], fb};
    end
    prbs_step8 = v;
  endfunction

endpackage

// ---- two_entry_buffer.sv ----
/*
  two-entry fifo with valid/ready on both sides and a flush.
  assumes: one clock, asynchronous active-high reset.
*/
`timescale 1ns/10ps
module two_entry_buffer #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             in_ready,
  output      logic             out_valid,
  output      logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  // pointers are one bit wide, so only two entries are served
  initial begin
    if (DEPTH != 2) $error("two_entry_buffer serves DEPTH 2 only");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];  // storage
  logic             wr_reg;           // write pointer
  logic             rd_reg;           // read pointer
  logic [1:0]       cnt_reg;          // fill level
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != 2'd2);
  assign out_valid = (cnt_reg != 2'd0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage needs no reset; pointers guard it
  always_ff @(posedge clock) begin
    if (push) mem_reg[wr_reg] <= in_data;
  end

  // pointers and fill level
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_reg  <= 1'b0;
      rd_reg  <= 1'b0;
      cnt_reg <= 2'd0;
    end else if (flush) begin
      wr_reg  <= 1'b0;
      rd_reg  <= 1'b0;
      cnt_reg <= 2'd0;
    end else begin
      if (push) wr_reg <= ~wr_reg;
      if (pop)  rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ---- link_pattern_gen.sv ----
/*
  per-link octet source: alignment sequence, live samples with
  opportunistic end-of-frame commas, and the test patterns.
  assumes: downstream buffer gives ready; run low holds all in reset.
*/
`timescale 1ns/10ps
module link_pattern_gen
  import link_cfg_pkg::*;
#(
  parameter int unsigned FRAME_OCTETS = FRAME_OCTETS_DEF,
  parameter int unsigned MF_OCTETS    = MF_FRAMES_DEF * FRAME_OCTETS_DEF
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire test_mode_t mode,
  input  wire logic [7:0] eof_code,
  input  wire logic [7:0] lane_id,
  input  wire logic       sample_valid,
  input  wire logic [7:0] sample_data,
  output      logic       sample_ready,
  output      lane_sym_t  sym,
  output      logic       sym_valid,
  input  wire logic       sym_ready,
  output      logic       ila_done
);
  localparam int unsigned OW = $clog2(MF_OCTETS);
  initial begin
    if (MF_OCTETS < 4 || MF_OCTETS > 256 || FRAME_OCTETS == 0 ||
        MF_OCTETS % FRAME_OCTETS != 0)
      $error("link_pattern_gen: bad frame geometry");
  end

  logic [OW-1:0] oct_reg;    // octet within multiframe
  logic [1:0]    mf_reg;     // multiframe within ila
  logic          ila_reg;    // alignment sequence pending
  logic [22:0]   lfsr_reg;   // prbs state
  logic [7:0]    ramp_reg;   // ramp value
  logic [3:0]    rpat_reg;   // rpat position
  logic [7:0]    last_reg;   // last sent sample octet
  logic          fire;
  logic          is_norm;
  logic          ila_ph;
  logic          mf_last;
  logic          frame_end;
  logic          eof_hit;
  lane_sym_t     ila_sym;

  assign fire      = sym_valid & sym_ready;
  assign is_norm   = (mode == TP_NORMAL);
  assign ila_ph    = (ila_reg & is_norm) | (mode == TP_REP_ILA);
  assign mf_last   = (oct_reg == OW'(MF_OCTETS - 1));
  assign frame_end = (32'(oct_reg) % FRAME_OCTETS) == FRAME_OCTETS - 1;
  assign eof_hit   = frame_end & (sample_data == last_reg);
  assign ila_done  = run & ~ila_reg;
  assign sym_valid = run & (ila_ph | ~is_norm | sample_valid);
  // live samples only flow once alignment is over
  assign sample_ready = run & is_norm & ~ila_reg & sym_ready;

  // alignment octets: R first, A last, Q then id in the second multiframe
  assign ila_sym.hold = HOLD_NONE;
  assign ila_sym.k = (oct_reg == '0) | mf_last |
                     ((mf_reg == 2'd1) & (oct_reg == OW'(1)));
  assign ila_sym.data =
    (oct_reg == '0) ? SYM_K28_0 :
    mf_last         ? SYM_K28_3 :
    (mf_reg == 2'd1 && oct_reg == OW'(1)) ? SYM_K28_4 :
    (mf_reg == 2'd1 && oct_reg == OW'(2)) ? lane_id :
    8'(oct_reg);

  // octet selection by mode
  always_comb begin
    sym = '{hold: HOLD_NONE, k: 1'b0, data: 8'h00};
    if (ila_ph) begin
      sym = ila_sym;
    end else begin
      case (mode)
        TP_NORMAL: begin
          sym.k    = eof_hit;
          sym.data = eof_hit ? eof_code : sample_data;
        end
        TP_PRBS7, TP_PRBS15, TP_PRBS23: sym.data = lfsr_reg[7:0];
        TP_RAMP:   sym.data = ramp_reg;
        TP_TRANSP: sym.data = lane_id ^ 8'(oct_reg);
        TP_D21_5:  sym.data = SYM_D21_5;
        TP_K28_5: begin
          sym.k    = 1'b1;
          sym.data = SYM_K28_5;
        end
        TP_RPAT:   sym.data = RPAT_SEQ[8*rpat_reg +: 8];
        TP_LOW:    sym.hold = HOLD_LOW;
        TP_HIGH:   sym.hold = HOLD_HIGH;
        default:   sym.data = 8'h00;   // reserved codes
      endcase
    end
  end

  // sequence state; a stopped link drops back to its start
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      oct_reg  <= '0;
      mf_reg   <= 2'd0;
      ila_reg  <= 1'b1;
      lfsr_reg <= '1;
      ramp_reg <= 8'h00;
      rpat_reg <= 4'h0;
      last_reg <= 8'h00;
    end else if (!run) begin
      oct_reg  <= '0;
      mf_reg   <= 2'd0;
      ila_reg  <= 1'b1;
      lfsr_reg <= '1;
      ramp_reg <= 8'h00;
      rpat_reg <= 4'h0;
      last_reg <= 8'h00;
    end else if (fire) begin
      oct_reg  <= mf_last ? '0 : oct_reg + OW'(1);
      if (mf_last) mf_reg <= mf_reg + 2'd1;
      if (mf_last && mf_reg == 2'(ILA_MFRAMES - 1)) ila_reg <= 1'b0;
      lfsr_reg <= prbs_step8(lfsr_reg, mode);
      ramp_reg <= ramp_reg + 8'h01;
      rpat_reg <= (rpat_reg == 4'(RPAT_LEN - 1)) ? 4'h0 : rpat_reg + 4'h1;
      if (is_norm) last_reg <= sample_data;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  ila_id_slot_a: assert property (
    sym_valid && ila_ph && mf_reg == 2'd1 && oct_reg == OW'(2)
    |-> sym.data == lane_id && !sym.k)
    else $error("id not sent in second multiframe");
  eof_repeat_a: assert property (
    sym_valid && !ila_ph && is_norm
    |-> sym.k == eof_hit && (!eof_hit || sym.data == eof_code))
    else $error("end-of-frame comma misplaced");
  d21_fixed_a: assert property (
    sym_valid && !ila_ph && mode == TP_D21_5
    ##1 sym_valid && mode == TP_D21_5
    |-> sym.data == SYM_D21_5 && !sym.k && sym.hold == HOLD_NONE)
    else $error("fixed pattern wrong");
  rsv_quiet_a: assert property (
    mode inside {TP_RSV12, TP_RSV13, TP_RSV14, TP_RSV15}
    |-> sym.hold == HOLD_NONE && !sym.k && sym.data == 8'h00)
    else $error("reserved mode produced a pattern");
  stop_clears_a: assert property (
    !run |=> oct_reg == '0 && ila_reg && mf_reg == 2'd0)
    else $error("sequence not held while stopped");
endmodule

// ---- lane_sink.sv ----
/* receiver model of the lane side: takes octets with random stalls,
   keeps the id octet and the first comma after alignment.
   assumes: clear is pulsed before each link start. */
`timescale 1ns/10ps
module lane_sink
  import link_cfg_pkg::*;
#(parameter int unsigned ILA_LEN = 16) (
  input  wire logic            clock,
  input  wire logic            clear,
  input  wire lane_sym_t [1:0] lane_sym,
  input  wire logic [1:0]      lane_valid,
  output      logic [1:0]      lane_ready = 2'b00,
  output      logic [1:0][7:0] id_seen,
  output      logic [1:0][7:0] eof_seen,
  output      logic [1:0]      eof_got
);
  int cnt [2];  // octets taken per lane since clear
  // random stalls: a receiver owes the sender no fixed rate
  always @(posedge clock) begin
    lane_ready <= 2'($urandom);
    for (int l = 0; l < 2; l++) begin
      if (clear) begin
        cnt[l] = 0;
        eof_got[l] <= 1'b0;
      end else if (lane_valid[l] && lane_ready[l]) begin
        // octet two of the second multiframe
        if (cnt[l] == ILA_LEN / 4 + 2) id_seen[l] <= lane_sym[l].data;
        if (cnt[l] >= ILA_LEN && lane_sym[l].k && !eof_got[l]) begin
          eof_seen[l] <= lane_sym[l].data;
          eof_got[l]  <= 1'b1;
        end
        cnt[l] = cnt[l] + 1;
      end
    end
  end
endmodule

// ---- serial_link_test_and_framing_cfg_tb.sv ----
/* self-checking bench: ahb register traffic, test modes, alignment id
   and end-of-frame comma on both links.
   assumes: one-slave bus, multiframe shortened to four octets. */
`timescale 1ns/10ps
module serial_link_test_and_framing_cfg_tb
  import link_cfg_pkg::*;
;
  logic clock = 0, sys_rst = 1, hsel = 0, hwrite = 0, dp = 0, clear = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, sample_valid = 0, lane_valid, lane_ready, got;
  logic [1:0] sample_ready;
  logic [1:0][7:0] sample_data = 0, id_seen, eof_seen;
  lane_sym_t [1:0] lane_sym;
  logic hreadyout, hresp, serializer_pd, link_clock_en;
  logic [31:0] expq [$];  // expected read data, oldest first
  logic [7:0] id;
  int failures = 0, checks = 0, n;
  localparam logic [31:0] A_CTL = 32'({IDX_LINK_CTRL, 2'b00});
  localparam logic [31:0] A_TST = 32'({IDX_TEST_SEL, 2'b00});
  localparam logic [31:0] A_ID = 32'({IDX_DEV_ID, 2'b00});
  localparam logic [31:0] A_FCH = 32'({IDX_FRAME_END_CHAR_SELECT, 2'b00});
  localparam logic [31:0] A_STS = 32'({IDX_STATUS, 2'b00});
  // first octet of test modes 1 to 12 as {hold, k, data}
  localparam logic [10:0] TP_EXP [12] = '{11'h0FF, 11'h0FF,
    11'h0FF, 11'h000, 11'h000, {3'h0, SYM_D21_5}, {3'h1, SYM_K28_5},
    {3'h1, SYM_K28_0}, {3'h0, RPAT_SEQ[7:0]}, 11'h200, 11'h400, 11'h000};
  localparam logic [7:0] EOF_TAB [4] = '{SYM_K28_7, SYM_K28_1,
                                         SYM_K28_5, SYM_K28_7};
  serial_link_test_and_framing_cfg #(.MF_FRAMES(4)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sample_valid(sample_valid),
    .sample_data(sample_data), .sample_ready(sample_ready),
    .lane_sym(lane_sym),
    .lane_valid(lane_valid), .lane_ready(lane_ready),
    .serializer_pd(serializer_pd), .link_clock_en(link_clock_en));
  lane_sink i_sink (.clock(clock), .clear(clear), .lane_sym(lane_sym),
    .lane_valid(lane_valid), .lane_ready(lane_ready),
    .id_seen(id_seen), .eof_seen(eof_seen), .eof_got(got));
  initial forever #12.5 clock = ~clock;
  task automatic chk(input string nm, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one single transfer; holds each phase until hready is seen high
  task automatic xfer(input logic w, input logic [31:0] a, d);
    @(posedge clock);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // read monitor: data phase ends at an edge with hready high
  always @(posedge clock) begin
    if (dp && hreadyout) begin
      chk("hrdata", expq.pop_front(), hrdata);
      chk("hresp", 0, hresp);
    end
    if (hreadyout) dp <= hsel && htrans[1] && !hwrite;
  end
  // sample source keeps an offer until it is taken; few values, so
  // repeats (and with them end-of-frame commas) come often
  always @(posedge clock) begin
    for (int l = 0; l < 2; l++)
      if (!sample_valid[l] || sample_ready[l]) begin
        sample_valid[l] <= 1'($urandom);
        sample_data[l] <= 8'($urandom % 2);
      end
  end
  initial begin
    #1_000_000;
    failures++;
    stop_test;
  end
  initial begin
    void'($urandom(18));
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    chk("en", 32'h0000_0001, {serializer_pd, link_clock_en});
    rd(A_CTL, 32'h0000_0001);
    rd(A_TST, 32'h0000_0000);
    rd(A_FCH, 32'h0000_0000);
    rd(32'h0000_0900, 32'h0000_0000);
    xfer(1'b1, A_CTL, 32'h0000_0000);
    chk("pd", 4'h8, {serializer_pd, link_clock_en, lane_valid});
    rd(A_STS, 32'h0000_0000);
    for (int m = 1; m < 13; m++) begin
      xfer(1'b1, A_TST, 32'(m));
      xfer(1'b1, A_CTL, 32'h0000_0001);
      for (n = 0; n < 50 && lane_valid[0] !== 1'b1; n++) @(posedge clock);
      chk("sym", 32'(TP_EXP[m-1]), 32'(lane_sym[0]));
      chk("srdy", 0, sample_ready);
      xfer(1'b1, A_CTL, 32'h0000_0000);
    end
    xfer(1'b1, A_TST, 32'h0000_0000);
    // every comma code; compliant use is code 0, generic 1 or 2
    for (int f = 0; f < 4; f++) begin
      id = 8'($urandom);
      xfer(1'b1, A_ID, 32'(id));
      rd(A_ID, 32'(id & 8'hFE));
      xfer(1'b1, A_FCH, 32'(f));
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
      xfer(1'b1, A_CTL, 32'h0000_0001);
      for (n = 0; n < 3000 && got !== 2'b11; n++) @(posedge clock);
      chk("id0", 32'(id & 8'hFE), 32'(id_seen[0]));
      chk("id1", 32'((id & 8'hFE) + 8'd1), 32'(id_seen[1]));
      chk("eof", 32'(EOF_TAB[f]), 32'(eof_seen[0]));
      chk("eof1", 32'(EOF_TAB[f]), 32'(eof_seen[1]));
      xfer(1'b1, A_CTL, 32'h0000_0000);
    end
    stop_test;
  end
endmodule
